// ---- design/slc_pkg.sv ----
// Constants and helpers shared by the serial link control register block.
// Assumes a 32-bit APB register port with one word per register index.
package slc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] SLC_IDX_TS_CTRL = 10'h160;
  localparam logic [9:0] SLC_IDX_LINK_ENABLE = 10'h200;
  localparam logic [9:0] SLC_IDX_OUTPUT_MODE = 10'h201;
  localparam logic [9:0] SLC_IDX_FRAMES_PER_MF = 10'h202;
  localparam logic [9:0] SLC_IDX_AUX_CTRL = 10'h210;
  localparam logic [9:0] SLC_IDX_STATUS = 10'h211;

  // Field positions and widths
  localparam int SLC_TS_INSERT_BIT = 0;
  localparam int SLC_LINK_ENABLE_BIT = 0;
  localparam int SLC_CAL_ENABLE_BIT = 0;
  localparam int SLC_TS_RECV_BIT = 1;
  localparam int SLC_MODE_WIDTH = 6;
  localparam int SLC_FPMF_WIDTH = 8;
  localparam int SLC_MF_WIDTH = 10;

  // Reset values
  localparam logic SLC_RST_TS_INSERT = 1'h0;
  localparam logic SLC_RST_LINK_ENABLE = 1'h1;
  localparam logic [5:0] SLC_RST_OUTPUT_MODE = 6'h00;
  localparam logic [7:0] SLC_RST_FPMF = 8'h1F;
  localparam logic SLC_RST_CAL_ENABLE = 1'h0;
  localparam logic SLC_RST_TS_RECV = 1'h0;
  localparam logic [3:0] SLC_CS_PER_SAMPLE = 4'h0;

  // Multiplier for the 64B/66B multiframe length
  localparam int SLC_EMB_FRAMES = 256;

  // Effective frames-per-multiframe minus one
  // A zero F gives a zero quotient, so the register value is used then
  function automatic logic [9:0] slc_eff_fpmf(input logic is64b, input logic [7:0] fpmfMinus1,
                                             input logic [7:0] e, input logic [7:0] f);
    logic [17:0] prod;
    logic [17:0] quot;
    prod = 18'(SLC_EMB_FRAMES) * 18'(e);
    quot = (f == 8'h00) ? 18'h00000 : prod / 18'(f);
    if (!is64b || quot == 18'h00000) begin
      slc_eff_fpmf = {2'h0, fpmfMinus1};
    end else if (quot > 18'h00400) begin
      slc_eff_fpmf = 10'h3FF;
    end else begin
      slc_eff_fpmf = 10'(quot - 18'h00001);
    end
  endfunction

endpackage

// ---- design/slc_ts_inserter.sv ----
// Sample path: places converter samples in the link sample field and
// optionally carries a timestamp on the field's lowest bit.
// Assumes the timestamp input is sampled alongside the converter sample.
`timescale 1ns/1ps
`default_nettype none
module slc_ts_inserter #(
  parameter int ADC_WIDTH = 12,
  parameter int LINK_WIDTH = 16,
  parameter int PIPE_DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic holdReset,
  input wire logic insertEnable,
  input wire logic [ADC_WIDTH-1:0] sampleIn,
  input wire logic timestampIn,
  output logic [LINK_WIDTH-1:0] sampleOut
);

  logic [ADC_WIDTH-1:0] samplePipe [PIPE_DEPTH];
  logic tsPipe [PIPE_DEPTH];
  logic [LINK_WIDTH-1:0] next_sampleOut;

  ////////////////////////////////////////////////////////////////////////////
  // Sample and timestamp travel through the same stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        samplePipe[i] <= '0;
        tsPipe[i] <= 1'b0;
      end
    end else if (enable) begin
      if (holdReset) begin
        for (int i = 0; i < PIPE_DEPTH; i++) begin
          samplePipe[i] <= '0;
          tsPipe[i] <= 1'b0;
        end
      end else begin
        samplePipe[0] <= sampleIn; // [R2]
        tsPipe[0] <= timestampIn; // [R2]
        for (int i = 1; i < PIPE_DEPTH; i++) begin
          samplePipe[i] <= samplePipe[i-1];
          tsPipe[i] <= tsPipe[i-1];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Left-justify data; lowest bit is padding, data or timestamp
  always_comb begin
    next_sampleOut = '0;
    next_sampleOut[LINK_WIDTH-1 -: ADC_WIDTH] = samplePipe[PIPE_DEPTH-1]; // [R4]
    if (insertEnable) begin
      next_sampleOut[0] = tsPipe[PIPE_DEPTH-1]; // [R1] [R4]
    end
  end

  // Output stage; without insertion the lowest bit is data or padding
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sampleOut <= '0;
    end else if (enable) begin
      sampleOut <= holdReset ? '0 : next_sampleOut; // [R19]
    end
  end

endmodule // slc_ts_inserter
`default_nettype wire

// ---- design/slc_mf_counter.sv ----
// Multiframe counter with SYSREF alignment.
// Assumes frameTick pulses once per frame and sysref is synchronous.
`timescale 1ns/1ps
`default_nettype none
module slc_mf_counter
  import slc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic holdReset,
  input wire logic frameTick,
  input wire logic sysref,
  input wire logic [SLC_MF_WIDTH-1:0] lastFrame,
  output logic [SLC_MF_WIDTH-1:0] count,
  output logic boundary
);

  ////////////////////////////////////////////////////////////////////////////
  // Counter held in reset while disabled; SYSREF ignored then
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      boundary <= 1'b0;
    end else if (enable) begin
      if (holdReset) begin
        count <= '0; // [R10]
        boundary <= 1'b0;
      end else if (sysref) begin
        count <= '0;
        boundary <= 1'b1;
      end else if (frameTick) begin
        if (count >= lastFrame) begin
          count <= '0;
          boundary <= 1'b1;
        end else begin
          count <= count + 1'b1;
          boundary <= 1'b0;
        end
      end else begin
        boundary <= 1'b0;
      end
    end
  end

endmodule // slc_mf_counter
`default_nettype wire

// ---- design/slc_link_regs.sv ----
// Top of the serial link control register block: APB slave, link
// enable/power controls, sample path with timestamp and multiframe counter.
// Assumes one clock, APB master on the same clock, mode decoding outside.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] Timestamp insertion set puts timestamp input on each sample's lowest bit.
// [R2] Timestamp is delayed exactly like the samples it marks.
// [R3] Software should also enable the timestamp receiver when inserting.
// [R4] Wider link field: timestamp at field bit 0, converter bits untouched.
// [R5] Lane alignment data reports zero control bits per sample, always.
// [R6] Link enable bit 0 disables, 1 enables; resets to 1.
// [R7] Software clears link enable before touching other link registers.
// [R8] Link disabled: link block held in reset, serializers powered down.
// [R9] Link disabled: link block clocks gated off.
// [R10] Link disabled: multiframe counter held in reset, SYSREF ignored.
// [R11] Software sets calibration enable before link enable.
// [R12] Software clears link enable before calibration enable.
// [R13] Six-bit output mode field in bits 5:0, resets to zero.
// [R14] Software changes mode only with link and calibration both disabled.
// [R15] Software writes reserved bits as zero.
// [R16] Frames-per-multiframe register holds K minus one, resets to 0x1F.
// [R17] In 64B/66B modes effective K is 256 times E over F; the block caps K at 1024 and uses the register when E or F is zero.
// [R18] Software changes frames-per-multiframe only with link disabled.
// [R19] Without insertion the lowest bit carries data or padding only.
module slc_link_regs
  import slc_pkg::*;
#(
  parameter int ADC_WIDTH = 12,
  parameter int LINK_WIDTH = 16,
  parameter int PIPE_DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode parameters decoded outside from the output mode
  input wire logic encoding64b66b,
  input wire logic [7:0] multiblocksE,
  input wire logic [7:0] frameOctetsF,
  // Sample and timing inputs
  input wire logic [ADC_WIDTH-1:0] sampleIn,
  input wire logic timestampIn,
  input wire logic frameTick,
  input wire logic sysref,
  // Link controls and data
  output logic linkEnable,
  output logic linkBlockReset_n,
  output logic serializerPowerDown,
  output logic linkClockEnable,
  output logic calEnable,
  output logic tsInputReceiverEnable,
  output logic [SLC_MODE_WIDTH-1:0] linkOutputMode,
  output logic [SLC_MF_WIDTH-1:0] effFramesMinus1,
  output logic [3:0] ilaControlBitsPerSample,
  output logic [LINK_WIDTH-1:0] linkSample,
  output logic [SLC_MF_WIDTH-1:0] multiframeCount,
  output logic multiframeBoundary
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic tsLsbInsertEnable;
  logic [SLC_FPMF_WIDTH-1:0] framesPerMultiframeMinus1;
  logic [SLC_MF_WIDTH-1:0] next_effFramesMinus1;
  logic [9:0] regIndex;
  logic wordAligned;
  logic setupPhase;
  logic writeStrobe;
  logic indexMapped;
  logic [31:0] readValue;
  logic linkHold;
  logic linkRun;

  // Decode the register index from the byte address
  function automatic logic slc_is_mapped(input logic [9:0] idx);
    slc_is_mapped = (idx == SLC_IDX_TS_CTRL) || (idx == SLC_IDX_LINK_ENABLE) ||
                    (idx == SLC_IDX_OUTPUT_MODE) || (idx == SLC_IDX_FRAMES_PER_MF) ||
                    (idx == SLC_IDX_AUX_CTRL) || (idx == SLC_IDX_STATUS);
  endfunction

  assign regIndex = paddr[11:2];
  assign wordAligned = (paddr[1:0] == 2'h0);
  assign indexMapped = wordAligned && slc_is_mapped(regIndex);
  assign setupPhase = psel && !penable && !pready;
  assign writeStrobe = psel && penable && pready && pwrite && !pslverr;

  // Link held while disabled; state frozen by ce
  assign linkHold = !linkEnable; // [R8] [R10]
  assign linkRun = ce && linkEnable; // [R9]

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; reserved bits read as zero
  always_comb begin
    readValue = 32'h0000_0000;
    unique case (regIndex)
      SLC_IDX_TS_CTRL: begin
        readValue[SLC_TS_INSERT_BIT] = tsLsbInsertEnable;
      end
      SLC_IDX_LINK_ENABLE: begin
        readValue[SLC_LINK_ENABLE_BIT] = linkEnable;
      end
      SLC_IDX_OUTPUT_MODE: begin
        readValue[SLC_MODE_WIDTH-1:0] = linkOutputMode;
      end
      SLC_IDX_FRAMES_PER_MF: begin
        readValue[SLC_FPMF_WIDTH-1:0] = framesPerMultiframeMinus1;
      end
      SLC_IDX_AUX_CTRL: begin
        readValue[SLC_CAL_ENABLE_BIT] = calEnable;
        readValue[SLC_TS_RECV_BIT] = tsInputReceiverEnable;
      end
      SLC_IDX_STATUS: begin
        readValue[SLC_MF_WIDTH-1:0] = multiframeCount;
        readValue[16 +: SLC_MF_WIDTH] = effFramesMinus1;
        readValue[31] = linkEnable;
      end
      default: begin
        readValue = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait-free access phase, error on unmapped address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (setupPhase) begin
        pready <= 1'b1;
        pslverr <= !indexMapped;
        prdata <= (!pwrite && indexMapped) ? readValue : 32'h0000_0000;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp control register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tsLsbInsertEnable <= SLC_RST_TS_INSERT;
    end else if (ce && writeStrobe && regIndex == SLC_IDX_TS_CTRL) begin
      tsLsbInsertEnable <= pwdata[SLC_TS_INSERT_BIT]; // [R1]
    end
  end

  // Link enable register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkEnable <= SLC_RST_LINK_ENABLE; // [R6]
    end else if (ce && writeStrobe && regIndex == SLC_IDX_LINK_ENABLE) begin
      linkEnable <= pwdata[SLC_LINK_ENABLE_BIT]; // [R6]
    end
  end

  // Output mode register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkOutputMode <= SLC_RST_OUTPUT_MODE; // [R13]
    end else if (ce && writeStrobe && regIndex == SLC_IDX_OUTPUT_MODE) begin
      linkOutputMode <= pwdata[SLC_MODE_WIDTH-1:0]; // [R13]
    end
  end

  // Frames-per-multiframe register, stored as K minus one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      framesPerMultiframeMinus1 <= SLC_RST_FPMF; // [R16]
    end else if (ce && writeStrobe && regIndex == SLC_IDX_FRAMES_PER_MF) begin
      framesPerMultiframeMinus1 <= pwdata[SLC_FPMF_WIDTH-1:0]; // [R16]
    end
  end

  // Calibration and timestamp receiver enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      calEnable <= SLC_RST_CAL_ENABLE;
      tsInputReceiverEnable <= SLC_RST_TS_RECV;
    end else if (ce && writeStrobe && regIndex == SLC_IDX_AUX_CTRL) begin
      calEnable <= pwdata[SLC_CAL_ENABLE_BIT];
      tsInputReceiverEnable <= pwdata[SLC_TS_RECV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link power and reset controls follow the enable bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkBlockReset_n <= 1'b0;
      serializerPowerDown <= 1'b1;
      linkClockEnable <= 1'b0;
    end else if (ce) begin
      linkBlockReset_n <= linkEnable; // [R8]
      serializerPowerDown <= !linkEnable; // [R8]
      linkClockEnable <= linkEnable; // [R9]
    end
  end

  // Lane alignment data never advertises a control bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ilaControlBitsPerSample <= SLC_CS_PER_SAMPLE;
    end else if (ce) begin
      ilaControlBitsPerSample <= SLC_CS_PER_SAMPLE; // [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective multiframe length; register ignored in 64B/66B modes unless E or F is zero
  assign next_effFramesMinus1 = slc_eff_fpmf(encoding64b66b, framesPerMultiframeMinus1,
                                             multiblocksE, frameOctetsF); // [R17]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      effFramesMinus1 <= {2'h0, SLC_RST_FPMF};
    end else if (ce) begin
      effFramesMinus1 <= next_effFramesMinus1; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample path runs on ce and is held cleared while the link is disabled
  slc_ts_inserter #(
    .ADC_WIDTH(ADC_WIDTH),
    .LINK_WIDTH(LINK_WIDTH),
    .PIPE_DEPTH(PIPE_DEPTH)
  ) u_ts_inserter (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ce),
    .holdReset(linkHold),
    .insertEnable(tsLsbInsertEnable),
    .sampleIn(sampleIn),
    .timestampIn(timestampIn),
    .sampleOut(linkSample)
  );

  // Multiframe counter, held while the link is disabled
  slc_mf_counter u_mf_counter (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ce),
    .holdReset(linkHold),
    .frameTick(frameTick && linkRun),
    .sysref(sysref && linkRun), // [R10]
    .lastFrame(effFramesMinus1),
    .count(multiframeCount),
    .boundary(multiframeBoundary)
  );

endmodule // slc_link_regs
`default_nettype wire

// ---- bench/slc_link_rx.sv ----
// Link receiver model: captures each transmitted sample word.
// Assumes one sample per clk while the link clocks run.
`timescale 1ns/1ps
`default_nettype none
module slc_link_rx #(
  parameter int LINK_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic linkClockEnable,
  input wire logic [LINK_WIDTH-1:0] linkSample,
  output logic [LINK_WIDTH-1:0] rxWord
);
  // Capture while clocks run; a gated lane inverts every bit of the last word each clk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxWord <= '0;
    end else if (linkClockEnable) begin
      rxWord <= linkSample;
    end else begin
      rxWord <= ~rxWord;
    end
  end
endmodule // slc_link_rx
`default_nettype wire

// ---- bench/slc_link_regs_assertions.sv ----
// Port checker for the serial link control block.
// Assumes one clock clk and asynchronous active-low reset_n.
`timescale 1ns/1ps
`default_nettype none
module slc_link_regs_checker
  import slc_pkg::*;
#(
  parameter int ADC_WIDTH = 12,
  parameter int LINK_WIDTH = 16,
  parameter int PIPE_DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ADC_WIDTH-1:0] sampleIn,
  input wire logic linkEnable,
  input wire logic linkBlockReset_n,
  input wire logic serializerPowerDown,
  input wire logic linkClockEnable,
  input wire logic [3:0] ilaControlBitsPerSample,
  input wire logic [LINK_WIDTH-1:0] linkSample,
  input wire logic [SLC_MF_WIDTH-1:0] multiframeCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("No answer after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("Error without ready");
  property p_enrst; $rose(reset_n) |-> linkEnable; endproperty
  a_enrst: assert property (p_enrst) else $error("Enable not set at reset");
  property p_power; !linkEnable |=> !linkBlockReset_n && serializerPowerDown; endproperty
  a_power: assert property (p_power) else $error("Link not held");
  // The reset edge itself leaves the gate at its reset value, so skip it
  property p_gate; $past(reset_n) |-> linkClockEnable == $past(linkEnable); endproperty
  a_gate: assert property (p_gate) else $error("Clock gate wrong");
  property p_hold; !linkEnable |=> multiframeCount == '0; endproperty
  a_hold: assert property (p_hold) else $error("Counter not held");
  property p_ila; ilaControlBitsPerSample == 4'h0; endproperty
  a_ila: assert property (p_ila) else $error("Control bits advertised");
  // The pipeline is cleared at the reset edge, so that edge opens no window
  property p_lat;
    (reset_n && linkEnable) [*4] |->
      linkSample[LINK_WIDTH-1 -: ADC_WIDTH] == $past(sampleIn, 3);
  endproperty
  a_lat: assert property (p_lat) else $error("Sample delay wrong");
  property p_pad; linkEnable [*4] |-> linkSample[LINK_WIDTH-ADC_WIDTH-1:1] == '0; endproperty
  a_pad: assert property (p_pad) else $error("Pad bits set");
  // Main scenarios
  c_off: cover property (!linkEnable);
  c_err: cover property (pslverr);
  c_run: cover property (linkEnable [*8]);
endmodule // slc_link_regs_checker
bind slc_link_regs slc_link_regs_checker #(.ADC_WIDTH(ADC_WIDTH), .LINK_WIDTH(LINK_WIDTH),
  .PIPE_DEPTH(PIPE_DEPTH)) u_chk (.clk, .reset_n, .psel, .penable, .pready, .pslverr,
  .sampleIn, .linkEnable, .linkBlockReset_n, .serializerPowerDown, .linkClockEnable,
  .ilaControlBitsPerSample, .linkSample, .multiframeCount);
`default_nettype wire

// ---- bench/tb_serial_link_ctrl_regs.sv ----
// Testbench: APB master, register and sample-path model, link receiver.
// Assumes the checker is bound into the design.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_link_ctrl_regs
  import slc_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic encoding64b66b = 1'b0, timestampIn = 1'b0, frameTick = 1'b0, sysref = 1'b0;
  logic [11:0] paddr = 12'h000, sampleIn = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] multiblocksE = 8'h01, frameOctetsF = 8'h01;
  logic pready, pslverr, linkEnable, linkBlockReset_n, serializerPowerDown, linkClockEnable;
  logic calEnable, tsInputReceiverEnable, multiframeBoundary, mOn = 1'b1, mIns = 1'b0;
  logic [5:0] linkOutputMode;
  logic [9:0] effFramesMinus1, multiframeCount;
  logic [3:0] ilaControlBitsPerSample;
  logic [15:0] linkSample, rxWord;
  logic [11:0] qS[$];
  logic qT[$];
  logic [31:0] regs[logic [9:0]];
  int numErrors = 0, compares = 0, offCnt = 0, bnd = 0;
  slc_link_regs dut (.clk, .reset_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .encoding64b66b, .multiblocksE, .frameOctetsF, .sampleIn, .timestampIn,
    .frameTick, .sysref, .linkEnable, .linkBlockReset_n, .serializerPowerDown,
    .linkClockEnable, .calEnable, .tsInputReceiverEnable, .linkOutputMode, .effFramesMinus1,
    .ilaControlBitsPerSample, .linkSample, .multiframeCount, .multiframeBoundary);
  slc_link_rx rx (.clk, .reset_n, .linkClockEnable, .linkSample, .rxWord);
  ////////////////////////////////////////////////////////////////////////////
  task automatic stopTest();
    $display("Compares %0d, mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "no pready");
      stopTest();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mask(input logic [9:0] idx);
    case (idx)
      10'h201: return 32'h3F;
      10'h202: return 32'hFF;
      10'h210: return 32'h3;
      default: return 32'h1;
    endcase
  endfunction
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {idx, 2'b00}, d, r, e);
    chk({31'h0, e}, 32'h0, "write refused");
    if (regs.exists(idx)) regs[idx] = d & mask(idx);
    if (idx == 10'h200) mOn <= d[0];
    if (idx == 10'h160) mIns <= d[0];
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, expErr}, "error flag");
  endtask
  task automatic rdr(input logic [9:0] idx);
    rd({idx, 2'b00}, regs[idx], 1'b0);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse(input logic isRef);
    @(posedge clk);
    sysref <= isRef;
    frameTick <= !isRef;
    @(posedge clk);
    sysref <= 1'b0;
    frameTick <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog, random samples and boundary count
  initial forever #10 clk = ~clk;
  initial begin
    repeat (100000) @(posedge clk);
    chk(32'h0, 32'h1, "timeout");
    stopTest();
  end
  always @(posedge clk) begin
    sampleIn <= 12'($urandom);
    timestampIn <= 1'($urandom);
  end
  always @(posedge clk) if (multiframeBoundary === 1'b1) bnd++;
  // Sample model: sent samples are compared at the receiver
  always @(posedge clk) begin
    if (!reset_n || !mOn) begin
      qS.delete();
      qT.delete();
      offCnt++;
      if (offCnt > 2 && reset_n) chk({16'h0, linkSample}, 32'h0, "sample off");
    end else begin
      offCnt = 0;
      qS.push_back(sampleIn);
      qT.push_back(mIns & timestampIn);
      if (qS.size() == 5) chk({16'h0, rxWord},
        {16'h0, qS.pop_front(), 3'h0, qT.pop_front()}, "sample");
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] k;
    int eE;
    int fF;
    void'($urandom(12));
    regs[10'h160] = 32'h0;
    regs[10'h200] = 32'h1;
    regs[10'h201] = 32'h0;
    regs[10'h202] = 32'h1F;
    regs[10'h210] = 32'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    chk({31'h0, linkEnable}, 32'h1, "enable reset");
    foreach (regs[i]) rdr(i);
    rd(12'h900, 32'h0, 1'b1);
    rd(12'h802, 32'h0, 1'b1);
    wr(10'h211, 32'hFFFFFFFF);
    chk({28'h0, ilaControlBitsPerSample}, 32'h0, "ila");
    $display("Test reset done");
    // Link off: held, gated, counter ignores sysref
    wr(10'h200, 32'h0);
    wr(10'h210, 32'h0);
    pulse(1'b1);
    settle(1);
    chk({29'h0, linkBlockReset_n, serializerPowerDown, linkClockEnable}, 32'h2,
      "hold");
    chk({22'h0, multiframeCount}, 32'h0, "count held");
    for (int m = 0; m < 64; m++) begin
      wr(10'h201, 32'(m));
      rdr(10'h201);
    end
    chk({26'h0, linkOutputMode}, 32'h3F, "mode");
    k = $urandom_range(254, 1);
    wr(10'h202, k);
    rdr(10'h202);
    chk({22'h0, effFramesMinus1}, k, "k");
    rd(12'h844, {6'h0, k[9:0], 16'h0}, 1'b0);
    repeat (6) begin
      eE = $urandom_range(3, 1);
      fF = $urandom_range(8, 1);
      @(posedge clk);
      encoding64b66b <= 1'b1;
      multiblocksE <= eE[7:0];
      frameOctetsF <= fF[7:0];
      settle(1);
      chk({22'h0, effFramesMinus1}, 256 * eE / fF - 1, "k 64b");
    end
    // Clock enable low freezes the length; then saturation and a zero F
    @(posedge clk);
    ce <= 1'b0;
    multiblocksE <= 8'hFF;
    frameOctetsF <= 8'h01;
    settle(2);
    chk({22'h0, effFramesMinus1}, 256 * eE / fF - 1, "ce freeze");
    @(posedge clk);
    ce <= 1'b1;
    settle(1);
    chk({22'h0, effFramesMinus1}, 32'h3FF, "k saturate");
    @(posedge clk);
    frameOctetsF <= 8'h00;
    settle(1);
    chk({22'h0, effFramesMinus1}, k, "k fallback");
    @(posedge clk);
    encoding64b66b <= 1'b0;
    $display("Test configuration done");
    // Stream with timestamp on, then off
    wr(10'h202, 32'h3);
    wr(10'h160, 32'h1);
    wr(10'h210, 32'h3);
    wr(10'h200, 32'h1);
    chk({30'h0, tsInputReceiverEnable, calEnable}, 32'h3, "aux");
    repeat (40) @(posedge clk);
    wr(10'h200, 32'h0);
    wr(10'h160, 32'h0);
    wr(10'h200, 32'h1);
    repeat (40) @(posedge clk);
    $display("Test stream done");
    // Counter wraps after K frames and aligns on sysref
    for (int i = 1; i <= 10; i++) begin
      pulse(1'b0);
      settle(0);
      chk({22'h0, multiframeCount}, i % 4, "count");
    end
    pulse(1'b1);
    settle(2);
    chk({22'h0, multiframeCount}, 32'h0, "align");
    chk(bnd, 3, "boundaries");
    wr(10'h200, 32'h0);
    pulse(1'b1);
    pulse(1'b0);
    settle(2);
    chk(bnd, 3, "off boundaries");
    $display("Test counter done");
    stopTest();
  end
endmodule // tb_serial_link_ctrl_regs
`default_nettype wire
